// file: rtl/cfgma_regs.svh
/*
  token codes, message field lengths and resource-id layout for the
  configuration message access block.
  assumes: included by bare name from the two rtl modules, not from the package.
*/
`ifndef CFGMA_REGS_SVH
`define CFGMA_REGS_SVH

// control tokens
`define CFGMA_TOK_WRITE 8'hC0
`define CFGMA_TOK_READ 8'hC1
`define CFGMA_TOK_ACK 8'h03
`define CFGMA_TOK_NACK 8'h04
`define CFGMA_TOK_END 8'h01

// reply id low byte that suppresses a write reply
`define CFGMA_NO_REPLY 8'hFF

// status-register resource id: number in bits 15:8, type code in 7:0
`define CFGMA_PS_TYPE 8'h0B
`define CFGMA_PS_NUM_LSB 8
`define CFGMA_PS_NUM_MSB 15

// field lengths, as count of bytes minus one
`define CFGMA_DEST_LAST 3'h2
`define CFGMA_REGN_LAST 3'h1
`define CFGMA_DATA_LAST 3'h3

`endif

// file: rtl/cfgma_pkg.sv
/*
  types of the configuration message access block: state enums and the
  packed state records of the interpreter and the reply sender.
  assumes: cfgma_regs.svh is on the include path.
*/
package cfgma_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEST, ST_REGN, ST_DATA, ST_END, ST_DRAIN, ST_ACCESS, ST_PSACC, ST_REPLY
  } cfgma_st_t;

  typedef enum logic [1:0] {TX_IDLE, TX_HEAD, TX_DATA, TX_TAIL} cfgma_tx_st_t;

  typedef struct packed {
    cfgma_st_t st;
    logic [23:0] dest;
    logic [15:0] regNum;
    logic [31:0] data;
    logic [2:0] cnt;
    logic isWrite;
    logic inReady;
    logic regReq;
    logic regWrite;
    logic regSpace;
    logic psDone;
    logic psErr;
    logic [31:0] psRdata;
    logic start;
    logic ok;
  } cfgma_main_t;

  typedef struct packed {
    cfgma_tx_st_t st;
    logic valid;
    logic ctrl;
    logic [7:0] byteOut;
    logic [23:0] dest;
    logic [31:0] data;
    logic [1:0] cnt;
    logic withData;
    logic busy;
  } cfgma_tx_t;

endpackage

// file: rtl/cfgma_reply_if.sv
/*
  carrier between the message interpreter and the reply sender.
  assumes: both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface cfgma_reply_if;
  logic start;
  logic ok;
  logic withData;
  logic [31:0] data;
  logic [23:0] dest;
  logic busy;

  modport main (output start, output ok, output withData, output data, output dest, input busy);
  modport tx (input start, input ok, input withData, input data, input dest, output busy);
endinterface

`default_nettype wire

// file: rtl/cfgma_reply_tx.sv
/*
  reply sender: emits ack or nack token, optional 32-bit data msb first,
  then the end token, toward the reply channel-end.
  assumes: start is a one-cycle pulse only while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfgma_regs.svh"

module cfgma_reply_tx (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request from the interpreter
  cfgma_reply_if.tx rep,
  // reply token stream
  input wire logic outReady,
  output logic outValid,
  output logic outCtrl,
  output logic [7:0] outByte,
  output logic [23:0] outDest
);
  import cfgma_pkg::*;

  cfgma_tx_t q;
  cfgma_tx_t d;
  logic sent;

  // one token leaves when valid meets ready
  assign sent = q.valid && outReady;

  // token sequencer
  always_comb begin
    d = q;
    case (q.st)
      TX_IDLE: begin
        if (rep.start) begin
          d.st = TX_HEAD;
          d.valid = 1'b1;
          d.ctrl = 1'b1;
          d.byteOut = rep.ok ? `CFGMA_TOK_ACK : `CFGMA_TOK_NACK;
          d.dest = rep.dest;
          d.data = rep.data;
          d.withData = rep.ok && rep.withData;
          d.busy = 1'b1;
        end
      end
      TX_HEAD: begin
        if (sent) begin
          if (q.withData) begin
            d.st = TX_DATA;
            d.ctrl = 1'b0;
            d.byteOut = q.data[31:24];
            d.data = {q.data[23:0], 8'h00};
            d.cnt = 2'h3;
          end else begin
            d.st = TX_TAIL;
            d.byteOut = `CFGMA_TOK_END;
          end
        end
      end
      TX_DATA: begin
        if (sent) begin
          if (q.cnt == 2'h0) begin
            d.st = TX_TAIL;
            d.ctrl = 1'b1;
            d.byteOut = `CFGMA_TOK_END;
          end else begin
            d.byteOut = q.data[31:24];
            d.data = {q.data[23:0], 8'h00};
            d.cnt = q.cnt - 2'h1;
          end
        end
      end
      default: begin
        if (sent) begin
          d.st = TX_IDLE;
          d.valid = 1'b0;
          d.ctrl = 1'b0;
          d.busy = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state record
  assign outValid = q.valid;
  assign outCtrl = q.ctrl;
  assign outByte = q.byteOut;
  assign outDest = q.dest;
  assign rep.busy = q.busy;

endmodule

`default_nettype wire

// file: rtl/cfgma_msg_access.sv
/*
  configuration message interpreter: parses write and read request
  messages from the token stream, runs one register access on the
  backend, and hands the reply to the reply sender. also serves the
  processor status-register word read and write port.
  assumes: the token stream, backend and processor port share ref_clk;
  the backend answers each held regReq with a one-cycle regAck.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfgma_regs.svh"

module cfgma_msg_access (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request token stream
  input wire logic inValid,
  input wire logic inCtrl,
  input wire logic [7:0] inByte,
  output logic inReady,
  // reply token stream
  input wire logic outReady,
  output logic outValid,
  output logic outCtrl,
  output logic [7:0] outByte,
  output logic [23:0] outDest,
  // register backend
  output logic regReq,
  output logic regWrite,
  output logic regSpace,
  output logic [15:0] regAddr,
  output logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic regErr,
  input wire logic [31:0] regRdata,
  // processor status-register port
  input wire logic psReq,
  input wire logic psWrite,
  input wire logic [31:0] psResId,
  input wire logic [31:0] psWdata,
  output logic psDone,
  output logic psErr,
  output logic [31:0] psRdata
);
  import cfgma_pkg::*;

  cfgma_main_t q;
  cfgma_main_t d;
  logic take;
  logic isEnd;

  cfgma_reply_if rep ();

  // close a message: reply unless a write asks for silence
  function automatic cfgma_main_t finishMsg(cfgma_main_t s, logic okFlag);
    cfgma_main_t r;
    r = s;
    r.ok = okFlag;
    if (s.isWrite && s.dest[7:0] == `CFGMA_NO_REPLY) begin
      r.st = ST_IDLE;
    end else begin
      r.st = ST_REPLY;
      r.start = 1'b1;
    end
    return r;
  endfunction

  // a token is consumed when valid meets ready
  assign take = inValid && q.inReady;
  assign isEnd = inCtrl && inByte == `CFGMA_TOK_END;

  // message parser and access sequencer
  always_comb begin
    d = q;
    d.psDone = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (take && inCtrl && inByte == `CFGMA_TOK_WRITE) begin
          d.st = ST_DEST;
          d.isWrite = 1'b1;
          d.cnt = `CFGMA_DEST_LAST;
        end else if (take && inCtrl && inByte == `CFGMA_TOK_READ) begin
          d.st = ST_DEST;
          d.isWrite = 1'b0;
          d.cnt = `CFGMA_DEST_LAST;
        end else if (psReq && !q.psDone) begin
          if (psResId[7:0] == `CFGMA_PS_TYPE && psResId[31:16] == 16'h0000) begin
            d.st = ST_PSACC;
            d.regReq = 1'b1;
            d.regSpace = 1'b1;
            d.regWrite = psWrite;
            d.regNum = {8'h00, psResId[`CFGMA_PS_NUM_MSB:`CFGMA_PS_NUM_LSB]};
            d.data = psWdata;
          end else begin
            d.psDone = 1'b1;
            d.psErr = 1'b1;
            d.psRdata = 32'h0000_0000;
          end
        end
      end
      ST_DEST, ST_REGN, ST_DATA: begin
        if (take) begin
          if (inCtrl) begin
            d = isEnd ? finishMsg(q, 1'b0) : q;
            d.psDone = 1'b0;
            if (!isEnd) begin
              d.st = ST_DRAIN;
            end
          end else if (q.st == ST_DEST) begin
            d.dest = {q.dest[15:0], inByte};
            d.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h0) begin
              d.st = ST_REGN;
              d.cnt = `CFGMA_REGN_LAST;
            end
          end else if (q.st == ST_REGN) begin
            d.regNum = {q.regNum[7:0], inByte};
            d.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h0) begin
              d.st = q.isWrite ? ST_DATA : ST_END;
              d.cnt = `CFGMA_DATA_LAST;
            end
          end else begin
            d.data = {q.data[23:0], inByte};
            d.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h0) begin
              d.st = ST_END;
            end
          end
        end
      end
      ST_END: begin
        if (take) begin
          if (isEnd) begin
            d.st = ST_ACCESS;
            d.regReq = 1'b1;
            d.regSpace = 1'b0;
            d.regWrite = q.isWrite;
          end else begin
            d.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // discard until the closing token, then report failure
        if (take && isEnd) begin
          d = finishMsg(q, 1'b0);
          d.psDone = 1'b0;
        end
      end
      ST_ACCESS: begin
        if (regAck) begin
          d = finishMsg(q, !regErr);
          d.psDone = 1'b0;
          d.regReq = 1'b0;
          if (!q.isWrite) begin
            d.data = regRdata;
          end
        end
      end
      ST_PSACC: begin
        if (regAck) begin
          d.st = ST_IDLE;
          d.regReq = 1'b0;
          d.psDone = 1'b1;
          d.psErr = regErr;
          d.psRdata = q.regWrite ? 32'h0000_0000 : regRdata;
        end
      end
      default: begin
        // wait for the sender to take and finish the reply
        d.start = 1'b0;
        if (!q.start && !rep.busy) begin
          d.st = ST_IDLE;
        end
      end
    endcase
    // tokens are taken only while parsing or draining
    d.inReady = (d.st == ST_IDLE || d.st == ST_DEST || d.st == ST_REGN ||
                 d.st == ST_DATA || d.st == ST_END || d.st == ST_DRAIN);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // reply request toward the sender
  assign rep.start = q.start;
  assign rep.ok = q.ok;
  assign rep.withData = !q.isWrite;
  assign rep.data = q.data;
  assign rep.dest = q.dest;

  // outputs straight from the state record
  assign inReady = q.inReady;
  assign regReq = q.regReq;
  assign regWrite = q.regWrite;
  assign regSpace = q.regSpace;
  assign regAddr = q.regNum;
  assign regWdata = q.data;
  assign psDone = q.psDone;
  assign psErr = q.psErr;
  assign psRdata = q.psRdata;

  // reply token sender
  cfgma_reply_tx u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rep(rep.tx),
    .outReady(outReady),
    .outValid(outValid),
    .outCtrl(outCtrl),
    .outByte(outByte),
    .outDest(outDest)
  );

endmodule

`default_nettype wire

// file: testbench/cfgma_chk.sv
/*
  checker of the message access block: timing of backend, reply and status port.
  assumes: bound to cfgma_msg_access, one clock, rst_n low active.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgma_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // reply stream
  input wire logic outReady,
  input wire logic outValid,
  input wire logic outCtrl,
  input wire logic [7:0] outByte,
  // backend
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic regSpace,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic regErr,
  input wire logic [31:0] regRdata,
  // status port
  input wire logic [31:0] psResId,
  input wire logic [31:0] psWdata,
  input wire logic psDone,
  input wire logic psErr,
  input wire logic [31:0] psRdata
);
  logic [1:0] idxQ;
  logic [31:0] rdQ;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // data byte position in a reply and the word last read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idxQ <= 2'h0;
    end else if (outValid && outReady) begin
      idxQ <= outCtrl ? 2'h0 : idxQ + 2'h1;
    end
    if (regAck && !regSpace) begin
      rdQ <= regRdata;
    end
  end
  // a control token taken, and the closing token shown
  sequence sTake(b);
    outValid && outReady && outCtrl && outByte == b;
  endsequence
  sequence sEnd;
    outValid && outCtrl && outByte == 8'h01;
  endsequence
  AST_REQ_HOLD: assert property (regReq && !regAck |=> regReq && $stable(regAddr)
    && $stable(regWrite) && $stable(regWdata)) else $error("backend request moved");
  AST_REQ_DROP: assert property (regReq && regAck |=> !regReq)
    else $error("backend request kept after ack");
  AST_RD_ACK: assert property (regAck && !regSpace && !regWrite && !regErr
    |-> ##2 outValid && outCtrl && outByte == 8'h03) else $error("read ack token");
  AST_RD_NACK: assert property (regAck && !regSpace && !regWrite && regErr
    |-> ##2 outValid && outCtrl && outByte == 8'h04) else $error("read nack token");
  AST_NACK_END: assert property (sTake(8'h04) |=> sEnd)
    else $error("failure reply not closed");
  AST_OUT_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outByte))
    else $error("reply token dropped");
  AST_DATA_MSB: assert property (outValid && !outCtrl |-> outByte == rdQ[31 - 8*idxQ -: 8])
    else $error("reply data order");
  AST_PS_ID: assert property (regReq && regSpace |-> regAddr == {8'h00, psResId[15:8]}
    && psResId == {16'h0000, psResId[15:8], 8'h0B}) else $error("status id");
  AST_PS_WR: assert property (regReq && regSpace && regWrite |-> regWdata == psWdata)
    else $error("status write word");
  AST_PS_RD: assert property (regAck && regSpace && !regWrite && !regErr
    |=> psDone && !psErr && psRdata == $past(regRdata)) else $error("status read word");
endmodule
`default_nettype wire

// file: testbench/cfgma_far_model.sv
/*
  far side model: register backend and reply sink.
  assumes: same clock as the block; slow gives late acks and a stalling sink.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgma_far_model (
  // clock, reset and pace
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  // backend
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic regAck,
  output logic regErr,
  output logic [31:0] regRdata,
  // reply sink
  output logic outReady
);
  logic [31:0] mem [16];
  logic [1:0] waitQ;
  // one held request answered; upper half of the map fails
  always_ff @(posedge ref_clk) begin
    regAck <= 1'b0;
    regRdata <= ~regRdata;  // no stale data between acks
    outReady <= !slow || !outReady;  // slow sink takes every other cycle
    if (!rst_n) begin
      waitQ <= 2'h0;
      regRdata <= 32'h0000_0000;
      outReady <= 1'b0;
    end else if (regReq && !regAck) begin
      if (waitQ != (slow ? 2'h3 : 2'h0)) begin
        waitQ <= waitQ + 2'h1;
      end else begin
        waitQ <= 2'h0;
        regAck <= 1'b1;
        regErr <= regAddr[15];
        regRdata <= mem[regAddr[3:0]];
        if (regWrite && !regAddr[15]) begin
          mem[regAddr[3:0]] <= regWdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
  testbench of the message access block: message table, status port, reset.
  assumes: design, far model and checker compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic wr; logic [23:0] id; logic [15:0] rg; logic [31:0] dat;
    logic [1:0] rep;} cfgma_row_t;
  logic ref_clk, rst_n, slow, inValid, inCtrl, inReady, outReady, outValid, outCtrl;
  logic [7:0] inByte, outByte;
  logic [23:0] outDest, lastDest;
  logic regReq, regWrite, regSpace, regAck, regErr, psReq, psWrite, psDone, psErr;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, psResId, psWdata, psRdata;
  logic [8:0] rq [$];
  int errorCnt = 0;
  int checked = 0;
  // rep: 0 no reply, 1 success, 2 failure
  cfgma_row_t rows [7] = '{'{1'b1, 24'h12_3456, 16'h0003, 32'hA5C3_0F81, 2'h1},
    '{1'b0, 24'h12_3457, 16'h0003, 32'hA5C3_0F81, 2'h1},
    '{1'b1, 24'h00_01FF, 16'h0004, 32'h1111_2222, 2'h0},
    '{1'b0, 24'h65_4321, 16'h0004, 32'h1111_2222, 2'h1},
    '{1'b1, 24'hAB_CDEF, 16'h8001, 32'h0000_0000, 2'h2},
    '{1'b0, 24'h0F_0E0D, 16'h8002, 32'h0000_0000, 2'h2},
    '{1'b1, 24'h22_22FF, 16'h8003, 32'h0000_0000, 2'h0}};
  cfgma_row_t bad = '{1'b1, 24'h13_5790, 16'h0000, 32'h0000_0000, 2'h2};
  cfgma_msg_access u_cfgma_msg_access (.ref_clk(ref_clk), .rst_n(rst_n), .inValid(inValid),
    .inCtrl(inCtrl), .inByte(inByte), .inReady(inReady), .outReady(outReady),
    .outValid(outValid), .outCtrl(outCtrl), .outByte(outByte), .outDest(outDest),
    .regReq(regReq), .regWrite(regWrite), .regSpace(regSpace), .regAddr(regAddr),
    .regWdata(regWdata), .regAck(regAck), .regErr(regErr), .regRdata(regRdata),
    .psReq(psReq), .psWrite(psWrite), .psResId(psResId), .psWdata(psWdata),
    .psDone(psDone), .psErr(psErr), .psRdata(psRdata));
  cfgma_far_model u_cfgma_far_model (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .regAck(regAck), .regErr(regErr), .regRdata(regRdata), .outReady(outReady));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // reply tokens as the sink takes them
  always @(posedge ref_clk) begin
    if (rst_n && outValid && outReady) begin
      rq.push_back({outCtrl, outByte});
      lastDest <= outDest;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic endSim();
    $display("checks %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one token, held until taken
  task automatic send(input logic c, input logic [7:0] b);
    inValid <= 1'b1;
    inCtrl <= c;
    inByte <= b;
    do @(posedge ref_clk); while (inReady !== 1'b1);
  endtask
  // requester routes to node id then C30C or node, peripheral, 02
  // whole request, or opener, id and end token only when cut
  task automatic msg(input cfgma_row_t r, input logic cut);
    send(1'b1, r.wr ? 8'hC0 : 8'hC1);
    for (int i = 2; i >= 0; i--) send(1'b0, r.id[8*i +: 8]);
    if (!cut) begin
      send(1'b0, r.rg[15:8]);
      send(1'b0, r.rg[7:0]);
      if (r.wr) for (int i = 3; i >= 0; i--) send(1'b0, r.dat[8*i +: 8]);
    end
    send(1'b1, 8'h01);
    inValid <= 1'b0;
    inByte <= ~inByte;  // released lines do not keep the last byte
  endtask
  // reply tokens against the row
  task automatic expRep(input cfgma_row_t r);
    logic [8:0] e [$];
    if (r.rep != 2'h0) e.push_back(r.rep == 2'h1 ? 9'h103 : 9'h104);
    if (r.rep == 2'h1 && !r.wr) for (int i = 3; i >= 0; i--) e.push_back({1'b0, r.dat[8*i +: 8]});
    if (r.rep != 2'h0) e.push_back(9'h101);
    repeat (48) @(posedge ref_clk);
    chk(32'(rq.size()), 32'(e.size()));
    foreach (e[i]) chk(32'(rq[i]), 32'(e[i]));
    if (r.rep != 2'h0) chk(32'(lastDest), 32'(r.id));
    rq.delete();
  endtask
  // status word access, request held until done
  task automatic ps(input logic w, input logic [31:0] id, input logic [31:0] wd,
    input logic err, input logic [31:0] rd);
    psReq <= 1'b1;
    psWrite <= w;
    psResId <= id;
    psWdata <= wd;
    do @(posedge ref_clk); while (psDone !== 1'b1);
    psReq <= 1'b0;
    chk(32'(psErr), 32'(err));
    chk(psRdata, rd);
    // let psReq stand low for one edge before the next request
    @(posedge ref_clk);
  endtask
  // reset held, outputs idle, then ready
  task automatic rstChk();
    repeat (10) @(posedge ref_clk);
    chk({30'h0, outValid, regReq}, 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'(inReady), 32'h1);
  endtask
  initial begin
    rst_n = 1'b0;
    slow = 1'b0;
    {inValid, inCtrl, inByte, psReq, psWrite, psResId, psWdata} = '0;
    rstChk();
    foreach (rows[i]) begin
      slow <= i[0];
      msg(rows[i], 1'b0);
      expRep(rows[i]);
    end
    msg(bad, 1'b1);
    expRep(bad);
    // junk token in idle, then a read drained by a stray control token
    send(1'b0, 8'h5A);
    send(1'b1, 8'hC1);
    for (int i = 2; i >= 0; i--) send(1'b0, bad.id[8*i +: 8]);
    send(1'b1, 8'h07);
    send(1'b0, 8'h33);
    send(1'b1, 8'h01);
    inValid <= 1'b0;
    expRep(bad);
    ps(1'b1, 32'h0000_050B, 32'hDEAD_BEEF, 1'b0, 32'h0000_0000);
    ps(1'b0, 32'h0000_050B, 32'h0000_0000, 1'b0, 32'hDEAD_BEEF);
    ps(1'b0, 32'h0000_050C, 32'h0000_0000, 1'b1, 32'h0000_0000);
    ps(1'b0, 32'h0001_050B, 32'h0000_0000, 1'b1, 32'h0000_0000);
    rst_n <= 1'b0;
    rstChk();
    endSim();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge ref_clk);
    errorCnt++;
    endSim();
  end
endmodule
bind cfgma_msg_access cfgma_chk u_cfgma_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .outReady(outReady), .outValid(outValid), .outCtrl(outCtrl), .outByte(outByte),
  .regReq(regReq), .regWrite(regWrite), .regSpace(regSpace), .regAddr(regAddr),
  .regWdata(regWdata), .regAck(regAck), .regErr(regErr), .regRdata(regRdata),
  .psResId(psResId), .psWdata(psWdata), .psDone(psDone), .psErr(psErr), .psRdata(psRdata));
`default_nettype wire
